//--- bench/autoneg_chk.sv
// checker: bus handshake and page register port properties
`timescale 1ns/10ps
`default_nettype none
module autoneg_chk
  import autoneg_pkg::*;
(
  // clock, reset and bus
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic [31:0]           s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  // negotiation side
  input wire logic                  pageSent,
  input wire logic                  sentToggle,
  input wire autoneg_pkg::tx_page_t txPage,
  input wire logic                  txToggle
);
  import autoneg_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [31:0] rdAddr;
  // read data is judged against the address taken at the handshake
  always_ff @(posedge core_clk)
    if (s_axi_arvalid && s_axi_arready)
      rdAddr <= s_axi_araddr;
  fixed_npable_a:
    assert property (s_axi_rvalid && rdAddr == 32'h18 |-> s_axi_rdata[2])
      else $error("next page able bit reads zero");
  upper_zero_a:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
      else $error("read data upper half not zero");
  unmapped_rd_a:
    assert property (s_axi_rvalid && !(rdAddr inside {32'h14, 32'h18, 32'h1c, 32'h20})
      |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
  rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read not answered in time");
  toggle_inv_a:
    assert property (pageSent |=> txToggle == !$past(sentToggle))
      else $error("transmit toggle not inverse of sent toggle");
  toggle_only_a:
    assert property (!pageSent |=> $stable(txToggle))
      else $error("transmit toggle moved without a sent page");
  tx_write_only_a:
    assert property ($changed(txPage) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)
      || $past(s_axi_wvalid, 3))
      else $error("transmit page changed without a write");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready && rdAddr == 32'h18);
  cover property (pageSent);
endmodule // autoneg_chk
`default_nettype wire

//--- bench/autoneg_page_registers_tb.sv
// testbench: register map, partner events, toggles and reset
`timescale 1ns/10ps
`default_nettype none
module autoneg_page_registers_tb;
  import autoneg_pkg::*;
  typedef struct packed {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e;
    logic [1:0] r;} row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, txToggle;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic anRestart, baseWordValid, nextWordValid, pageAcknowledged, parallelFault;
  logic partnerAnAble, pageSent, sentToggle;
  logic [15:0] baseWord;
  page_word_t nextWord;
  tx_page_t txPage;
  int failures = 0, n_checks = 0;
  row_t rows [11];
  logic [15:0] words [2] = '{16'ha9a5, 16'h565a};
  logic [6:0] evs [5] = '{7'h08, 7'h20, 7'h10, 7'h00, 7'h01};
  logic [4:0] exs [5] = '{5'h02, 5'h03, 5'h13, 5'h03, 5'h02};
  always #2.5 core_clk = ~core_clk;
  autoneg_page_registers autoneg_page_registers_inst (.core_clk, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .anRestart, .baseWordValid,
    .baseWord, .nextWordValid, .nextWord, .pageAcknowledged, .parallelFault, .partnerAnAble,
    .pageSent, .sentToggle, .txPage, .txToggle);
  link_partner_model partner (.core_clk, .anRestart, .baseWordValid, .baseWord,
    .nextWordValid, .nextWord, .pageAcknowledged, .parallelFault, .partnerAnAble, .pageSent,
    .sentToggle);
  task automatic test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait: a bus that never answers counts as a mismatch
  task automatic tick(inout int n);
    @(posedge core_clk);
    n++;
    if (n > 64)
    begin
      failures++;
      $display("CHECK FAILED at %0t: bus answer timed out", $time);
      test_done();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r);
    int n;
    logic aw, wd;
    n = 0;
    aw = 1'b1;
    wd = 1'b1;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || wd)
    begin
      tick(n);
      aw = aw && !s_axi_awready;
      wd = wd && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= wd;
    end
    do tick(n); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do tick(n); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do tick(n); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  initial
  begin
    rows = '{'{1'b0, 32'h14, 32'h0, 32'h0, RESP_OKAY}, '{1'b0, 32'h18, 32'h0, 32'h4, RESP_OKAY},
      '{1'b0, 32'h1c, 32'h0, 32'h2001, RESP_OKAY}, '{1'b0, 32'h20, 32'h0, 32'h0, RESP_OKAY},
      '{1'b1, 32'h1c, 32'hffffffff, 32'hb7ff, RESP_OKAY},
      '{1'b1, 32'h1c, 32'h0, 32'h0, RESP_OKAY}, '{1'b1, 32'h14, 32'hffffffff, 32'h0, RESP_OKAY},
      '{1'b1, 32'h18, 32'hffffffff, 32'h4, RESP_OKAY},
      '{1'b1, 32'h20, 32'hffffffff, 32'h0, RESP_OKAY},
      '{1'b1, 32'h40, 32'h1, 32'h0, RESP_SLVERR}, '{1'b0, 32'h10000014, 32'h0, 32'h0, RESP_SLVERR}};
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d, rows[i].r);
      rd(rows[i].a, rows[i].e, 32'hffffffff, rows[i].r);
    end
    chk({18'h0, txPage}, 32'h0);
    $display("register map test done");
    partner.ev(7'h02, 16'hffff);
    rd(32'h14, 32'hefff, 32'hffffffff, RESP_OKAY);
    rd(32'h18, 32'h000c, 32'hffffffff, RESP_OKAY);
    partner.ev(7'h01, 16'h0000);
    rd(32'h14, 32'h0, 32'h03ff, RESP_OKAY);
    foreach (words[i])
    begin
      partner.ev(7'h04, words[i]);
      rd(32'h20, {16'h0, words[i] ^ 16'h0800}, 32'hffffffff, RESP_OKAY);
    end
    $display("partner page test done");
    // ack, able, fault, plain read, restart: fault clears on read, page flag holds
    foreach (evs[i])
    begin
      if (evs[i] != 7'h00)
        partner.ev(evs[i], 16'h0000);
      rd(32'h18, {27'h0, exs[i]}, 32'h13, RESP_OKAY);
    end
    $display("expansion flag test done");
    for (int t = 0; t < 2; t++)
    begin
      partner.ev(7'h40, {4'h0, t[0], 11'h0});
      @(negedge core_clk);
      chk({31'h0, txToggle}, {31'h0, !t[0]});
      rd(32'h1c, {20'h0, !t[0], 11'h0}, 32'hffffffff, RESP_OKAY);
    end
    $display("toggle test done");
    rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
      rd(rows[i].a, rows[i].e, 32'hffffffff, rows[i].r);
    chk({18'h0, txPage}, 32'h1001);
    s_axi_wstrb <= 4'h1;
    wr(32'h1c, 32'hffffffff, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(32'h1c, 32'h20ff, 32'hffffffff, RESP_OKAY);
    $display("reset test done");
    test_done();
  end
endmodule // autoneg_page_registers_tb
bind autoneg_page_registers autoneg_chk autoneg_chk_inst (.core_clk, .rst, .s_axi_wvalid,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pageSent, .sentToggle, .txPage,
  .txToggle);
`default_nettype wire

//--- bench/link_partner_model.sv
// model of the remote partner events as seen by the page registers
`timescale 1ns/10ps
`default_nettype none
module link_partner_model
  import autoneg_pkg::*;
(
  // clock
  input wire logic                   core_clk,
  // events towards the page registers
  output var logic                   anRestart,
  output var logic                   baseWordValid,
  output var logic [15:0]            baseWord,
  output var logic                   nextWordValid,
  output var autoneg_pkg::page_word_t nextWord,
  output var logic                   pageAcknowledged,
  output var logic                   parallelFault,
  output var logic                   partnerAnAble,
  output var logic                   pageSent,
  output var logic                   sentToggle
);
  import autoneg_pkg::*;
  logic [6:0] evReg = 7'h00;
  // event strobes: restart, base, next, ack, fault, able, sent
  assign {pageSent, partnerAnAble, parallelFault, pageAcknowledged, nextWordValid,
    baseWordValid, anRestart} = evReg;
  initial
  begin
    baseWord = 16'h0000;
    nextWord = 16'h0000;
    sentToggle = 1'b0;
  end
  // one-cycle event; words are inverted afterwards so stale data never looks valid
  task automatic ev(input logic [6:0] e, input logic [15:0] w);
    @(posedge core_clk);
    evReg <= e;
    baseWord <= w;
    nextWord <= page_word_t'(w);
    sentToggle <= w[11];
    @(posedge core_clk);
    evReg <= 7'h00;
    baseWord <= ~w;
    nextWord <= page_word_t'(~w);
    sentToggle <= ~w[11];
  endtask
endmodule // link_partner_model
`default_nettype wire

//--- src/autoneg_page_registers.sv
// autoneg page register bank with an axi4-lite slave
// What this block does
// - partner ability bits 4:0 show partner selector; cleared on restart or reset
// - partner ability bits 9:5 show partner abilities; cleared on restart or reset
// - expansion bit 4 latches parallel detection fault; cleared by read or reset
// - expansion bit 3 always equals partner ability bit 15
// - expansion bit 2 reads constant one: local next pages supported
// - expansion bit 1 latches on acknowledged page; held until chip reset
// - expansion bit 0 reads one only once partner known autoneg able
// - transmit bit 15 writable next page flag, resets to zero
// - transmit bit 13 selects message or unformatted page, resets to one
// - transmit bit 12 writable comply flag, resets to zero
// - transmit bit 11 read-only, inverse of previously sent toggle
// - transmit code field writable, resets to one
// - message and unformatted codes are both eleven bits wide
// - received bit 15 read-only, partner wants further next pages
// - received bit 14 read-only, partner acknowledged our ability word
// - received bit 13 read-only, partner sent message page
// - received bit 12 read-only, partner will comply
// - received bit 11 holds inverse of partner's previous toggle
// - received code field read-only, resets to zero
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module autoneg_page_registers
  import autoneg_pkg::*;
(
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // axi4-lite write address and data
  input  wire logic [31:0]               s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output var  logic                      s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output var  logic                      s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]                s_axi_bresp,
  output var  logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0]               s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output var  logic                      s_axi_arready,
  output var  logic [31:0]               s_axi_rdata,
  output var  logic [1:0]                s_axi_rresp,
  output var  logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // negotiation restart (same clock as the bus, no synchroniser needed)
  input  wire logic                      anRestart,
  // partner base and next page words
  input  wire logic                      baseWordValid,
  input  wire logic [15:0]               baseWord,
  input  wire logic                      nextWordValid,
  input  wire autoneg_pkg::page_word_t   nextWord,
  // expansion flag events
  input  wire logic                      pageAcknowledged,
  input  wire logic                      parallelFault,
  input  wire logic                      partnerAnAble,
  // transmit toggle bookkeeping
  input  wire logic                      pageSent,
  input  wire logic                      sentToggle,
  // transmit page towards the negotiation state machine
  output var  autoneg_pkg::tx_page_t     txPage,
  output var  logic                      txToggle
);

  // register state
  logic [SELECTOR_W-1:0] selector_reg;
  logic [ABILITY_W-1:0]  ability_reg;
  logic [15:10]          abilityHigh_reg;
  // latched expansion flags
  logic                  fault_reg;
  logic                  pageRx_reg;
  logic                  lpAnAble_reg;
  // locally owned transmit page
  tx_page_t              tx_reg;
  logic                  txToggle_reg;
  page_word_t            rx_reg;

  // bus state
  logic                  awHeld_reg;
  logic                  wHeld_reg;
  logic [9:0]            awAddr_reg;
  logic [31:0]           wData_reg;
  logic [3:0]            wStrb_reg;
  logic                  doWrite;
  logic                  readTake;
  logic                  expRead;
  logic [15:0]           readWord;
  logic                  readHit;
  logic                  readInRange;
  logic                  writeHit;
  logic                  txWriteHi;
  logic                  txWriteLo;

  // write channels accepted independently, in either order
  assign doWrite  = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  assign readTake = s_axi_arvalid && s_axi_arready;
  // upper address bits must be zero; the low ten bits select the word
  assign readInRange = (s_axi_araddr[31:10] == 22'h000000);
  assign expRead  = readTake && readInRange && (s_axi_araddr[9:0] == AUTONEG_EXPANSION_ADDR);

  // write decode; out-of-range addresses were folded to an unmapped word at capture
  assign writeHit = (awAddr_reg == PARTNER_ABILITY_ADDR) ||
                    (awAddr_reg == AUTONEG_EXPANSION_ADDR) ||
                    (awAddr_reg == NEXT_PAGE_TRANSMIT_ADDR) ||
                    (awAddr_reg == PARTNER_NEXT_PAGE_RECEIVED_ADDR);

  // byte lanes of the transmit word; bits 14 and 11 never take write data
  assign txWriteHi = doWrite && (awAddr_reg == NEXT_PAGE_TRANSMIT_ADDR) && wStrb_reg[1];
  assign txWriteLo = doWrite && (awAddr_reg == NEXT_PAGE_TRANSMIT_ADDR) && wStrb_reg[0];

  // address channel capture
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      awHeld_reg    <= 1'b0;
      awAddr_reg    <= 10'h000;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      awHeld_reg    <= 1'b1;
      awAddr_reg    <= (s_axi_awaddr[31:10] == 22'h000000) ? s_axi_awaddr[9:0] : 10'h3ff;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      if (doWrite)
        awHeld_reg <= 1'b0;
      // ready only while the holding slot is free, so no address is dropped
      s_axi_awready <= !awHeld_reg && !s_axi_awready && !doWrite;
    end
  end

  // data channel capture
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wHeld_reg    <= 1'b0;
      wData_reg    <= 32'h00000000;
      wStrb_reg    <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wHeld_reg    <= 1'b1;
      wData_reg    <= s_axi_wdata;
      wStrb_reg    <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      if (doWrite)
        wHeld_reg <= 1'b0;
      s_axi_wready <= !wHeld_reg && !s_axi_wready && !doWrite;
    end
  end

  // write response; unmapped address answers slverr
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= writeHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // transmit next page: only the writable fields take data, the rest ignore it
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tx_reg.nextPage <= NP_NEXT_RST;
      tx_reg.msgPage  <= NP_MSG_RST;
      tx_reg.comply   <= NP_COMPLY_RST;
      tx_reg.code     <= NP_CODE_RST;
    end
    else
    begin
      if (txWriteHi)
      begin
        tx_reg.nextPage <= wData_reg[NP_NEXT_BIT];
        tx_reg.msgPage  <= wData_reg[NP_MSG_BIT];
        tx_reg.comply   <= wData_reg[NP_COMPLY_BIT];
        tx_reg.code[10:8] <= wData_reg[10:8];
      end
      if (txWriteLo)
        tx_reg.code[7:0] <= wData_reg[7:0];
    end
  end

  // toggle kept by negotiation: inverse of the toggle last sent
  always_ff @(posedge core_clk)
  begin
    if (rst)
      txToggle_reg <= 1'b0;
    else if (pageSent)
      txToggle_reg <= !sentToggle;
  end

  // partner base page; restart clears selector and abilities
  always_ff @(posedge core_clk)
  begin
    if (rst || anRestart)
    begin
      selector_reg    <= '0;
      ability_reg     <= '0;
      abilityHigh_reg <= '0;
    end
    else if (baseWordValid)
    begin
      selector_reg    <= baseWord[SELECTOR_LSB +: SELECTOR_W];
      ability_reg     <= baseWord[ABILITY_LSB +: ABILITY_W];
      abilityHigh_reg <= {baseWord[15:13], 1'b0, baseWord[11:10]};
    end
  end

  // partner next page; the toggle is stored inverted
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rx_reg.nextPage <= 1'b0;
      rx_reg.ack      <= 1'b0;
      rx_reg.msgPage  <= 1'b0;
      rx_reg.comply   <= 1'b0;
      rx_reg.toggle   <= 1'b0;
      rx_reg.code     <= RX_CODE_RST;
    end
    else if (nextWordValid)
    begin
      rx_reg.nextPage <= nextWord.nextPage;
      rx_reg.ack      <= nextWord.ack;
      rx_reg.msgPage  <= nextWord.msgPage;
      rx_reg.comply   <= nextWord.comply;
      rx_reg.toggle   <= !nextWord.toggle;
      rx_reg.code     <= nextWord.code;
    end
  end

  // parallel fault latch; a new fault in the read cycle wins over the clear
  always_ff @(posedge core_clk)
  begin
    if (rst)
      fault_reg <= 1'b0;
    else if (parallelFault)
      fault_reg <= 1'b1;
    else if (expRead)
      fault_reg <= 1'b0;
  end

  // page received stays set until chip reset; a restart does not clear it
  always_ff @(posedge core_clk)
  begin
    if (rst)
      pageRx_reg <= 1'b0;
    else if (pageAcknowledged)
      pageRx_reg <= 1'b1;
  end

  // partner ability is forgotten on restart until a fresh exchange shows it
  always_ff @(posedge core_clk)
  begin
    if (rst || anRestart)
      lpAnAble_reg <= 1'b0;
    else if (partnerAnAble)
      lpAnAble_reg <= 1'b1;
  end

  // read mux; reserved bits read zero, no write reaches status bits
  always_comb
  begin
    readWord = 16'h0000;
    readHit  = 1'b1;
    case (s_axi_araddr[9:0])
      PARTNER_ABILITY_ADDR:
        readWord = {abilityHigh_reg, ability_reg, selector_reg};
      AUTONEG_EXPANSION_ADDR:
      begin
        readWord[EXP_FAULT_BIT]    = fault_reg;
        readWord[EXP_LPNP_BIT]     = abilityHigh_reg[15];
        readWord[EXP_NPABLE_BIT]   = 1'b1;
        readWord[EXP_PAGERX_BIT]   = pageRx_reg;
        readWord[EXP_LPANABLE_BIT] = lpAnAble_reg;
      end
      NEXT_PAGE_TRANSMIT_ADDR:
        readWord = {tx_reg.nextPage, 1'b0, tx_reg.msgPage, tx_reg.comply,
                    txToggle_reg, tx_reg.code};
      PARTNER_NEXT_PAGE_RECEIVED_ADDR:
        readWord = rx_reg;
      default:
        readHit = 1'b0;
    endcase
    if (!readInRange)
      readHit = 1'b0;
  end

  // read address ready: offered every other idle cycle, withdrawn while an answer waits
  always_ff @(posedge core_clk)
  begin
    if (rst)
      s_axi_arready <= 1'b0;
    else if (readTake || s_axi_rvalid)
      s_axi_arready <= 1'b0;
    else
      s_axi_arready <= !s_axi_arready;
  end

  // read answer: captured at acceptance, held until rready; a refused read returns zero
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (readTake)
    begin
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= readHit ? {16'h0000, readWord} : 32'h00000000;
      s_axi_rresp   <= readHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid  <= 1'b0;
  end

  // outputs straight from flops
  assign txPage   = tx_reg;
  assign txToggle = txToggle_reg;

endmodule // autoneg_page_registers

`default_nettype wire

//--- src/autoneg_pkg.sv
// package: register map, field layout, reset values and carriers for autoneg page registers
package autoneg_pkg;

  // register word indices; the bus byte address is the index times four
  localparam logic [7:0] PARTNER_ABILITY_IDX            = 8'h05;
  localparam logic [7:0] AUTONEG_EXPANSION_IDX          = 8'h06;
  localparam logic [7:0] NEXT_PAGE_TRANSMIT_IDX         = 8'h07;
  localparam logic [7:0] PARTNER_NEXT_PAGE_RECEIVED_IDX = 8'h08;
  localparam logic [9:0] PARTNER_ABILITY_ADDR            = {PARTNER_ABILITY_IDX, 2'b00};
  localparam logic [9:0] AUTONEG_EXPANSION_ADDR          = {AUTONEG_EXPANSION_IDX, 2'b00};
  localparam logic [9:0] NEXT_PAGE_TRANSMIT_ADDR         = {NEXT_PAGE_TRANSMIT_IDX, 2'b00};
  localparam logic [9:0] PARTNER_NEXT_PAGE_RECEIVED_ADDR = {PARTNER_NEXT_PAGE_RECEIVED_IDX, 2'b00};

  // field positions
  localparam int SELECTOR_LSB    = 0;
  localparam int SELECTOR_W      = 5;
  localparam int ABILITY_LSB     = 5;
  localparam int ABILITY_W       = 5;
  localparam int EXP_FAULT_BIT   = 4;
  localparam int EXP_LPNP_BIT    = 3;
  localparam int EXP_NPABLE_BIT  = 2;
  localparam int EXP_PAGERX_BIT  = 1;
  localparam int EXP_LPANABLE_BIT = 0;
  localparam int NP_NEXT_BIT     = 15;
  localparam int NP_ACK_BIT      = 14;
  localparam int NP_MSG_BIT      = 13;
  localparam int NP_COMPLY_BIT   = 12;
  localparam int NP_TOGGLE_BIT   = 11;
  localparam int CODE_W          = 11;

  // reset values
  localparam logic               NP_NEXT_RST   = 1'b0;
  localparam logic               NP_MSG_RST    = 1'b1;
  localparam logic               NP_COMPLY_RST = 1'b0;
  localparam logic [CODE_W-1:0]  NP_CODE_RST   = 11'h001;
  localparam logic [CODE_W-1:0]  RX_CODE_RST   = 11'h000;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // one received link code word, as decoded by the negotiation state machine
  typedef struct packed {
    logic              nextPage;
    logic              ack;
    logic              msgPage;
    logic              comply;
    logic              toggle;
    logic [CODE_W-1:0] code;
  } page_word_t;

  // locally owned transmit next page fields
  typedef struct packed {
    logic              nextPage;
    logic              msgPage;
    logic              comply;
    logic [CODE_W-1:0] code;
  } tx_page_t;

endpackage
